// ---- fault_seq_pkg.sv ----
// Shared constants, types and register map of the protection sequencer.
package fault_seq_pkg;

    // Clock and timing.
    localparam int unsigned CLK_KHZ        = 50_000;
    localparam int unsigned CLK_PERIOD_NS  = 20;
    localparam int unsigned BLANK_MS       = 20;
    localparam int unsigned BLANK_CYC      = BLANK_MS * CLK_KHZ;
    localparam int unsigned SPIKE_NS       = 30_000;
    localparam int unsigned SPIKE_CYC      =
        (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned EXT_COUNT      = 256;

    // Register map, byte addresses.
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK   = 8'h08;
    localparam logic [7:0] REG_STATE  = 8'h0C;

    // Control field positions and reset values.
    localparam int unsigned CTRL_EXT_EN_BIT = 0;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
    localparam logic [31:0] MASK_RESET      = 32'h0000_0000;

    // Status event bits.
    localparam int unsigned EV_OVP1     = 0;
    localparam int unsigned EV_OVP2     = 1;
    localparam int unsigned EV_OVERLOAD = 2;
    localparam int unsigned EV_THERMAL  = 3;
    localparam int unsigned EV_EXT_TRIP = 4;
    localparam int unsigned EV_LOCKOUT  = 5;
    localparam int unsigned EV_RESUME   = 6;
    localparam int unsigned EV_NUM      = 7;

    // State readback field positions.
    localparam int unsigned ST_STATE_LSB = 0;
    localparam int unsigned ST_MODE_LSB  = 4;
    localparam int unsigned ST_CYCLE_LSB = 8;
    localparam int unsigned ST_EXTC_LSB  = 16;

    typedef enum logic [2:0] {
        ST_OFF, ST_SOFT, ST_RUN, ST_AR_WAIT, ST_AR_PROBE
    } seq_state_t;

    typedef enum logic [1:0] {
        MODE_NORMAL, MODE_ODD_SKIP, MODE_NON_SWITCH
    } restart_mode_t;

    typedef enum logic [1:0] {
        EB_IDLE, EB_DISCH, EB_CHARGE, EB_DONE
    } ext_blank_state_t;

    // Digitised flags from the analog front end, all active high.
    typedef struct packed {
        logic vcc_ovp1;      // supply above 20.5 V
        logic vcc_ovp2;      // supply above 25.5 V
        logic lockout;       // supply_lockout active, device unpowered
        logic fb_high;       // feedback_high_comparator, above 4.5 V
        logic pin_high;      // pin_high_comparator, above 4.5 V
        logic pin_low;       // multi_function_pin below 0.9 V
        logic pin_ext;       // multi_function_pin below 0.4 V
        logic temp_trip;     // junction above 130 C
        logic temp_release;  // junction 50 C below the trip point
        logic soft_done;     // soft start period finished
    } afe_flags_t;

    localparam int unsigned FLAG_W = $bits(afe_flags_t);

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

endpackage

// ---- flag_sync.sv ----
// Two-stage synchroniser for a vector of analog comparator flags.
module flag_sync
    import fault_seq_pkg::*;
#(
    parameter int unsigned WIDTH = FLAG_W
) (
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge core_clk) begin
            if (!reset_n) begin
                meta_ff[i]  <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta_ff[i]  <= async_in[i];
                sync_out[i] <= meta_ff[i];
            end
        end
    end

endmodule

// ---- fault_restart_seq.sv ----
// Protection sequencer: fault detection, blanking and auto-restart control.
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
module fault_restart_seq
    import fault_seq_pkg::*;
#(
    parameter int unsigned BLANK_CYCLES = BLANK_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire afe_flags_t  afe_flags,
    input  wire reg_req_t    reg_req,
    output logic [31:0]      reg_rdata,
    output logic             gate_enable,
    output logic             soft_start_en,
    output logic             startup_cell_en,
    output logic             charge_switch,
    output logic             discharge_switch,
    output logic             ext_blank_done,
    output logic             irq
);

    afe_flags_t        flg;
    seq_state_t        state_ff, nxt_state;
    restart_mode_t     mode_ff, nxt_mode;
    ext_blank_state_t  eb_ff, nxt_eb;
    logic [7:0]        cycle_ff, nxt_cycle;
    logic              lock_prev_ff;
    logic [1:0]        prime_ff;
    logic              hot_ff;
    logic [20:0]       blank_ff;
    logic              blank_done_ff;
    logic [8:0]        eb_cnt_ff;
    logic [10:0]       spike_ff;
    logic [31:0]       ctrl_ff, mask_ff, status_ff;
    logic [EV_NUM-1:0] events;

    flag_sync #(.WIDTH(FLAG_W)) u_sync (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .async_in (afe_flags),
        .sync_out (flg)
    );

    // Decoding of the sequencer condition.
    // The synchroniser clears to zero, which reads as powered; edges are
    // ignored until the real flag has reached its output.
    wire primed       = prime_ff[1];
    wire lock_on_ev   = primed & lock_prev_ff & ~flg.lockout;
    wire in_soft      = (state_ff == ST_SOFT) |
                        (state_ff == ST_AR_PROBE && mode_ff == MODE_ODD_SKIP);
    wire switching    = in_soft | (state_ff == ST_RUN);
    wire detect_en    = switching | (state_ff == ST_AR_PROBE);
    wire ovp1_hit     = in_soft & flg.vcc_ovp1 & flg.fb_high;
    wire ovp2_hit     = ~flg.lockout & flg.vcc_ovp2;
    wire ovl_gate     = (eb_ff == EB_DONE) & flg.fb_high;
    wire ovl_trip     = ovl_gate & (spike_ff == 11'(SPIKE_CYC - 1));
    wire fault_odd    = detect_en & (ovp1_hit | ovp2_hit | ovl_trip);
    wire fault_nonsw  = detect_en & (hot_ff | flg.pin_ext);
    wire fault_any    = fault_odd | fault_nonsw;
    wire blank_run    = switching & flg.fb_high;
    wire blank_last   = blank_ff == 21'(BLANK_CYCLES - 1);
    wire eb_last      = eb_cnt_ff == 9'(EXT_COUNT - 1);
    wire ext_en       = ctrl_ff[CTRL_EXT_EN_BIT];
    wire next_even    = ~nxt_cycle[0];

    // Non-switching faults win when both kinds appear together.
    wire restart_mode_t fault_mode = fault_nonsw ? MODE_NON_SWITCH
                                                 : MODE_ODD_SKIP;

    // Main protection state machine.
    always_comb begin
        nxt_state = state_ff;
        nxt_mode  = mode_ff;
        nxt_cycle = cycle_ff;
        case (state_ff)
            ST_OFF: begin
                if (lock_on_ev) begin
                    nxt_state = ST_SOFT;
                end
            end
            ST_SOFT, ST_RUN: begin
                if (flg.lockout) begin
                    nxt_state = ST_OFF;
                    nxt_mode  = MODE_NORMAL;
                end else if (fault_any) begin
                    nxt_state = ST_AR_WAIT;
                    nxt_mode  = fault_mode;
                    nxt_cycle = 8'h00;
                end else if (state_ff == ST_SOFT && flg.soft_done) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_AR_WAIT: begin
                // Odd cycles run no detection and never switch.
                if (lock_on_ev) begin
                    nxt_cycle = cycle_ff + 8'h01;
                    if (next_even) begin
                        nxt_state = ST_AR_PROBE;
                    end
                end
            end
            ST_AR_PROBE: begin
                if (flg.lockout) begin
                    nxt_state = ST_AR_WAIT;
                end else if (fault_any) begin
                    nxt_state = ST_AR_WAIT;
                    nxt_mode  = fault_mode;
                end else if (mode_ff == MODE_NON_SWITCH) begin
                    nxt_state = ST_SOFT;
                    nxt_mode  = MODE_NORMAL;
                end else if (flg.soft_done) begin
                    nxt_state = ST_RUN;
                    nxt_mode  = MODE_NORMAL;
                end
            end
            default: begin
                nxt_state = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_ff     <= ST_OFF;
            mode_ff      <= MODE_NORMAL;
            cycle_ff     <= 8'h00;
            lock_prev_ff <= 1'b1;
            prime_ff     <= 2'h0;
        end else begin
            state_ff     <= nxt_state;
            mode_ff      <= nxt_mode;
            cycle_ff     <= nxt_cycle;
            lock_prev_ff <= primed ? flg.lockout : 1'b1;
            if (!primed) begin
                prime_ff <= prime_ff + 2'h1;
            end
        end
    end

    // The thermal flag only releases through the cooler comparator.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            hot_ff <= 1'b0;
        end else if (flg.temp_trip) begin
            hot_ff <= 1'b1;
        end else if (flg.temp_release) begin
            hot_ff <= 1'b0;
        end
    end

    // Built-in blanking counter restarts whenever feedback falls back.
    always_ff @(posedge core_clk) begin
        if (!reset_n || !blank_run) begin
            blank_ff      <= 21'h000000;
            blank_done_ff <= 1'b0;
        end else if (blank_last) begin
            blank_done_ff <= 1'b1;
        end else if (!blank_done_ff) begin
            blank_ff <= blank_ff + 21'h000001;
        end
    end

    // Extended blanking: one count per discharge and recharge of the pin.
    always_comb begin
        nxt_eb = eb_ff;
        case (eb_ff)
            EB_IDLE: begin
                if (blank_done_ff) begin
                    nxt_eb = ext_en ? EB_DISCH : EB_DONE;
                end
            end
            EB_DISCH: begin
                if (flg.pin_low) begin
                    nxt_eb = EB_CHARGE;
                end
            end
            EB_CHARGE: begin
                if (flg.pin_high) begin
                    nxt_eb = eb_last ? EB_DONE : EB_DISCH;
                end
            end
            default: begin
                nxt_eb = EB_DONE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n || !blank_run) begin
            eb_ff     <= EB_IDLE;
            eb_cnt_ff <= 9'h000;
        end else begin
            eb_ff <= nxt_eb;
            if (eb_ff == EB_CHARGE && flg.pin_high) begin
                eb_cnt_ff <= eb_cnt_ff + 9'h001;
            end
        end
    end

    // Spike blanking delays the overload trip while the gate stays high.
    always_ff @(posedge core_clk) begin
        if (!reset_n || !ovl_gate) begin
            spike_ff <= 11'h000;
        end else if (!ovl_trip) begin
            spike_ff <= spike_ff + 11'h001;
        end
    end

    // Outputs to the power stage.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            charge_switch    <= 1'b0;
            discharge_switch <= 1'b0;
            ext_blank_done   <= 1'b0;
        end else begin
            charge_switch    <= nxt_eb == EB_CHARGE && blank_run;
            discharge_switch <= nxt_eb == EB_DISCH && blank_run;
            ext_blank_done   <= nxt_eb == EB_DONE && blank_run;
        end
    end

    // Gate drive falls in the same cycle the state leaves switching.
    assign gate_enable     = switching;
    assign soft_start_en   = in_soft;
    assign startup_cell_en = flg.lockout;

    // Register slave with sticky, write-one-to-clear status.
    assign events[EV_OVP1]     = ovp1_hit & detect_en;
    assign events[EV_OVP2]     = ovp2_hit & detect_en;
    assign events[EV_OVERLOAD] = ovl_trip & detect_en;
    assign events[EV_THERMAL]  = hot_ff & detect_en;
    assign events[EV_EXT_TRIP] = flg.pin_ext & detect_en;
    assign events[EV_LOCKOUT]  = flg.lockout & ~lock_prev_ff;
    assign events[EV_RESUME]   = state_ff == ST_AR_PROBE &&
                                 nxt_mode == MODE_NORMAL;

    wire wr_ctrl   = reg_req.wr && reg_req.addr == REG_CTRL;
    wire wr_status = reg_req.wr && reg_req.addr == REG_STATUS;
    wire wr_mask   = reg_req.wr && reg_req.addr == REG_MASK;
    wire [31:0] clr_bits  = wr_status ? reg_req.wdata : 32'h0000_0000;
    wire [31:0] ev_word   = {{(32 - EV_NUM){1'b0}}, events};
    wire [31:0] state_word =
        (32'(state_ff) << ST_STATE_LSB) | (32'(mode_ff) << ST_MODE_LSB) |
        (32'(cycle_ff) << ST_CYCLE_LSB) | (32'(eb_cnt_ff) << ST_EXTC_LSB);

    logic [31:0] rd_word;
    always_comb begin
        if (reg_req.addr == REG_CTRL) begin
            rd_word = ctrl_ff;
        end else if (reg_req.addr == REG_STATUS) begin
            rd_word = status_ff;
        end else if (reg_req.addr == REG_MASK) begin
            rd_word = mask_ff;
        end else if (reg_req.addr == REG_STATE) begin
            rd_word = state_word;
        end else begin
            rd_word = 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ctrl_ff   <= CTRL_RESET;
            mask_ff   <= MASK_RESET;
            status_ff <= 32'h0000_0000;
            reg_rdata <= 32'h0000_0000;
            irq       <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= reg_req.wdata & 32'h0000_0001;
            end
            if (wr_mask) begin
                mask_ff <= reg_req.wdata & ev_word_mask();
            end
            // A new event wins over a clear in the same cycle.
            status_ff <= (status_ff & ~clr_bits) | ev_word;
            reg_rdata <= reg_req.rd ? rd_word : 32'h0000_0000;
            irq       <= |(((status_ff & ~clr_bits) | ev_word) & mask_ff);
        end
    end

    function automatic logic [31:0] ev_word_mask();
        return {{(32 - EV_NUM){1'b0}}, {EV_NUM{1'b1}}};
    endfunction

    // Checks on the sequencer.
    a_odd_cycle_quiet: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        state_ff == ST_AR_WAIT |-> !gate_enable && !soft_start_en)
        else $error("gate active during a skipped restart cycle");

    a_even_soft_pulses: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        state_ff == ST_AR_PROBE && mode_ff == MODE_ODD_SKIP
        |-> gate_enable && soft_start_en && !cycle_ff[0])
        else $error("even odd-skip cycle lacks soft start pulses");

    a_resume_on_even: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        $past(state_ff) == ST_AR_PROBE && state_ff == ST_RUN
        |-> !cycle_ff[0] && mode_ff == MODE_NORMAL)
        else $error("normal operation resumed on an odd cycle");

    a_nonsw_no_gate: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        state_ff == ST_AR_PROBE && mode_ff == MODE_NON_SWITCH
        |-> !gate_enable)
        else $error("gate driven in a non-switching cycle");

    a_nonsw_resume: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        state_ff == ST_AR_PROBE && mode_ff == MODE_NON_SWITCH &&
        !fault_any && !flg.lockout |=> state_ff == ST_SOFT)
        else $error("fault-free non-switching cycle did not resume");

    a_fault_mapping: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        state_ff == ST_RUN && !flg.lockout && fault_nonsw
        |=> state_ff == ST_AR_WAIT && mode_ff == MODE_NON_SWITCH)
        else $error("thermal or pin trip not mapped to non-switching");

    a_ovp2_always: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        state_ff == ST_RUN && flg.vcc_ovp2 && !flg.lockout && !fault_nonsw
        |=> state_ff == ST_AR_WAIT && mode_ff == MODE_ODD_SKIP)
        else $error("supply over-voltage did not enter odd-skip");

    a_lockout_off: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        flg.lockout && state_ff inside {ST_SOFT, ST_RUN}
        |=> state_ff == ST_OFF && startup_cell_en && !gate_enable)
        else $error("lockout did not shut the switching down");

    a_switch_exclusive: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        eb_ff == EB_DISCH && flg.pin_low && blank_run
        |=> charge_switch && !discharge_switch)
        else $error("discharge did not hand over to charge");

    a_spike_blanking: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        $rose(ovl_gate) |-> !ovl_trip [*8])
        else $error("overload tripped inside spike blanking");

endmodule

// ---- afe_pin_model.sv ----
// Behavioural model of the multi-function pin and its comparators.
module afe_pin_model (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic charge_switch,
    input  wire logic discharge_switch,
    input  wire logic ext_pull,
    input  wire logic slow,
    output logic      pin_high,
    output logic      pin_low,
    output logic      pin_ext
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pin level in tenths of a volt; a tie-up resistor pulls it to 5 V.
    int   v_ff;
    logic tick_ff;
    always @(posedge core_clk) begin
        if (!reset_n) begin
            v_ff <= 50;
            tick_ff <= 1'b1;
        end else begin
            // A large capacitor is modelled by moving only every other cycle.
            tick_ff <= slow ? ~tick_ff : 1'b1;
            if (ext_pull) begin
                v_ff <= 0;
            end else if (!tick_ff) begin
                v_ff <= v_ff;
            end else if (discharge_switch) begin
                // The discharge path settles above the external trip level.
                v_ff <= (v_ff > 9) ? v_ff - 4 : 5;
            end else if (charge_switch) begin
                v_ff <= v_ff + 4;
            end else if (v_ff < 50) begin
                v_ff <= v_ff + 1;
            end
        end
    end
    assign pin_high = v_ff > 45;
    assign pin_low  = v_ff < 9;
    assign pin_ext  = v_ff < 4;
endmodule

// ---- smps_fault_restart_sequencer_tb_top.sv ----
// Self-checking bench of the protection sequencer with its pin model.
`define CHK(nm, e, g) check(nm, 32'(e), 32'(g));
module smps_fault_restart_sequencer_tb_top import fault_seq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned BLK = 20;
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    afe_flags_t  fl = '0;
    afe_flags_t  afe;
    reg_req_t    rq = '0;
    logic        ext_pull = 1'b0;
    logic        slow = 1'b0;
    logic [31:0] rdata;
    logic [31:0] d;
    logic        gate_enable, soft_start_en, startup_cell_en, irq;
    logic        charge_switch, discharge_switch, ext_blank_done;
    logic        p_hi, p_lo, p_ext;
    int          fail_count = 0;
    int          n_tests = 0;

    always #10 core_clk = ~core_clk;
    always_comb begin
        afe = fl;
        afe.pin_high = p_hi;
        afe.pin_low = p_lo;
        afe.pin_ext = p_ext;
    end

    fault_restart_seq #(.BLANK_CYCLES(BLK)) u_fault_restart_seq (
        .core_clk(core_clk), .reset_n(reset_n), .afe_flags(afe),
        .reg_req(rq), .reg_rdata(rdata), .gate_enable(gate_enable),
        .soft_start_en(soft_start_en), .startup_cell_en(startup_cell_en),
        .charge_switch(charge_switch), .discharge_switch(discharge_switch),
        .ext_blank_done(ext_blank_done), .irq(irq));
    afe_pin_model u_afe_pin_model (
        .core_clk(core_clk), .reset_n(reset_n), .charge_switch(charge_switch),
        .discharge_switch(discharge_switch), .ext_pull(ext_pull),
        .slow(slow), .pin_high(p_hi), .pin_low(p_lo), .pin_ext(p_ext));

    task automatic check(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic step(int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] v);
        @(posedge core_clk);
        rq.addr <= a;
        rq.wdata <= v;
        rq.wr <= 1'b1;
        @(posedge core_clk);
        rq.wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        rq.addr <= a;
        rq.rd <= 1'b1;
        @(posedge core_clk);
        rq.rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic st_is(seq_state_t s, restart_mode_t m);
        rd(REG_STATE, d);
        `CHK("state", s, d[2:0])
        `CHK("mode", m, d[5:4])
    endtask
    function automatic restart_mode_t mode_of(int k);
        case (k)
            EV_THERMAL, EV_EXT_TRIP: return MODE_NON_SWITCH;
            default: return MODE_ODD_SKIP;
        endcase
    endfunction
    function automatic seq_state_t ar_state(int c, restart_mode_t m, bit f);
        if (c % 2 == 1 || f) return ST_AR_WAIT;
        return (m == MODE_NON_SWITCH) ? ST_SOFT : ST_AR_PROBE;
    endfunction
    task automatic do_reset();
        @(posedge core_clk);
        reset_n <= 1'b0;
        fl <= '{lockout: 1'b1, default: 1'b0};
        ext_pull <= 1'b0;
        step(10);
        reset_n <= 1'b1;
    endtask
    // Soft start done is dropped so that a probe cycle stays observable.
    task automatic lock_cycle();
        @(posedge core_clk);
        fl.soft_done <= 1'b0;
        fl.lockout <= 1'b1;
        step(4 + ($urandom % 8));
        #1 `CHK("startup", 1'b1, startup_cell_en)
        fl.lockout <= 1'b0;
        step(6);
    endtask
    task automatic go_run();
        lock_cycle();
        st_is(ST_SOFT, MODE_NORMAL);
        `CHK("gate", 1'b1, gate_enable)
        `CHK("startup", 1'b0, startup_cell_en)
        fl.soft_done <= 1'b1;
        step(5);
        st_is(ST_RUN, MODE_NORMAL);
    endtask
    task automatic set_fault(int k, logic on);
        @(posedge core_clk);
        case (k)
            EV_OVP2: fl.vcc_ovp2 <= on;
            EV_THERMAL: begin
                fl.temp_trip <= on;
                fl.temp_release <= ~on;
            end
            default: ext_pull <= on;
        endcase
    endtask
    task automatic trip(int k);
        restart_mode_t m;
        seq_state_t    s;
        m = mode_of(k);
        do_reset();
        go_run();
        set_fault(k, 1'b1);
        step(5);
        st_is(ST_AR_WAIT, m);
        `CHK("gate", 1'b0, gate_enable)
        rd(REG_STATUS, d);
        `CHK("status", 1'b1, d[k])
        for (int c = 1; c <= 4; c++) begin
            if (c == 3) set_fault(k, 1'b0);
            lock_cycle();
            s = ar_state(c, m, c < 3);
            st_is(s, (s == ST_SOFT) ? MODE_NORMAL : m);
            if (s != ST_SOFT) `CHK("cycle", c, d[15:8])
            `CHK("gate", s inside {ST_AR_PROBE, ST_SOFT}, gate_enable)
            `CHK("soft", s inside {ST_AR_PROBE, ST_SOFT}, soft_start_en)
        end
        fl.soft_done <= 1'b1;
        step(5);
        st_is(ST_RUN, MODE_NORMAL);
    endtask

    initial begin
        repeat (90000) @(posedge core_clk);
        fail_count++;
        end_of_test();
    end

    initial begin
        logic [31:0] v;
        void'($urandom(32'hEF955CE2));
        do_reset();
        rd(REG_CTRL, d);
        `CHK("ctrl", CTRL_RESET, d)
        #20 `CHK("idle rdata", 32'h0, rdata)
        rd(REG_MASK, d);
        `CHK("mask", MASK_RESET, d)
        st_is(ST_OFF, MODE_NORMAL);
        for (int i = 0; i < 6; i++) begin
            v = $urandom;
            wr(REG_MASK, v);
            rd(REG_MASK, d);
            `CHK("mask", v & 32'h7F, d)
        end
        wr(8'h10, $urandom);
        rd(8'h10, d);
        `CHK("unmapped", 32'h0, d)
        wr(REG_CTRL, 32'hFFFF_FFFE);
        rd(REG_CTRL, d);
        `CHK("ctrl", 32'h0, d)
        wr(REG_CTRL, 32'h1);
        wr(REG_MASK, 32'h0);
        // Supply high with feedback high outside soft start is ignored.
        go_run();
        @(posedge core_clk);
        fl.vcc_ovp1 <= 1'b1;
        fl.fb_high <= 1'b1;
        step(8);
        fl.fb_high <= 1'b0;
        step(5);
        st_is(ST_RUN, MODE_NORMAL);
        lock_cycle();
        fl.fb_high <= 1'b1;
        step(5);
        st_is(ST_AR_WAIT, MODE_ODD_SKIP);
        for (int i = 0; i < 3; i++) begin
            trip(i == 0 ? EV_OVP2 : i == 1 ? EV_THERMAL : EV_EXT_TRIP);
        end
        wr(REG_MASK, 32'h1 << EV_OVP2);
        step(2);
        `CHK("irq", 1'b0, irq)
        do_reset();
        go_run();
        set_fault(EV_OVP2, 1'b1);
        step(5);
        wr(REG_MASK, 32'h1 << EV_OVP2);
        step(2);
        `CHK("irq", 1'b1, irq)
        set_fault(EV_OVP2, 1'b0);
        step(4);
        wr(REG_STATUS, 32'h1 << EV_OVP2);
        rd(REG_STATUS, d);
        `CHK("status", 1'b0, d[EV_OVP2])
        `CHK("irq", 1'b0, irq)
        // Overload: built-in blanking, 256 pin cycles, then spike delay.
        do_reset();
        go_run();
        slow <= 1'($urandom % 2);
        @(posedge core_clk);
        fl.fb_high <= 1'b1;
        step(BLK);
        #1 `CHK("disch", 1'b0, discharge_switch)
        for (int i = 0; i < 12 && discharge_switch !== 1'b1; i++) step(1);
        #1 `CHK("disch", 1'b1, discharge_switch)
        for (int i = 0; i < 200 && charge_switch !== 1'b1; i++) step(1);
        #1 `CHK("charge", 1'b1, charge_switch)
        for (int i = 0; i < 40000 && ext_blank_done !== 1'b1; i++) step(1);
        #1 `CHK("done", 1'b1, ext_blank_done)
        rd(REG_STATE, d);
        `CHK("ext count", EXT_COUNT, d[24:16])
        step(SPIKE_CYC - 20);
        st_is(ST_RUN, MODE_NORMAL);
        step(30);
        st_is(ST_AR_WAIT, MODE_ODD_SKIP);
        `CHK("gate", 1'b0, gate_enable)
        end_of_test();
    end
endmodule
